// ==== rtl/ccs_portable_end.sv ====
// Purpose: Portable end of the cipher mode switch handshake
// Assumes: Frame timing arrives from the fixed end on clk_sys
// Notes:   Key stream and payload path live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_portable_end
    import ccs_pkg::*;
(
    input  wire logic         clk_sys,                    // System clock
    input  wire logic         rst,                        // Async reset
    ccs_link_if.portable_side link,                       // Link to fixed end
    input  wire logic         duplex_ok,                  // Duplex bearer up
    input  wire logic         cipher_switch_request,      // Toggle mode pulse
    input  wire logic         handover_done,              // Handover end pulse
    input  wire logic         connect_request,            // Reopen pulse
    output logic              cipher_switch_confirmation, // Confirm pulse
    output logic              disconnect_indication,      // Release pulse
    output logic              tx_encrypt,                 // Encrypt sent data
    output logic              rx_decrypt,                 // Decrypt received
    output logic              rx_discard,                 // Ignore received
    output logic              rx_keystream_run,           // Run rx key stream
    output logic              bearer_mode_encrypted,      // Mode for bearers
    output logic              connected                   // Connection live
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        ccs_pt_state_e st;
        logic [3:0]    fnum;
        logic [2:0]    tries;
        logic          resume;
        logic          tx_valid;
        ccs_cmd_e      tx_cmd;
        logic          tx_enc;
        logic          rx_dec;
        logic          rx_disc;
        logic          ks_run;
        logic          mode_enc;
        logic          cfm;
        logic          disc;
    } ccs_pt_s;

    localparam logic [2:0] REQ_TRIES = `CCS_REQ_TRIES;

    ccs_pt_s s;
    ccs_pt_s next_s;

    logic    rx_ok;
    logic    send_slot;
    logic    grant_frame;

    // ---------------------------------------------------------------
    // Link qualifiers
    // ---------------------------------------------------------------
    // Fixed end messages count only on a duplex bearer
    assign rx_ok       = link.ft_tail_valid & duplex_ok;
    // Own slot: second half of an even frame
    assign send_slot   = link.half_tick & ccs_is_even(s.fnum);
    assign grant_frame = link.frame_tick & ccs_is_even(link.frame_num);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s          = s;
        next_s.tx_valid = 1'b0;
        next_s.tx_cmd   = CMD_NONE;
        next_s.cfm      = 1'b0;
        next_s.disc     = 1'b0;
        if (link.frame_tick) begin
            next_s.fnum = link.frame_num;
        end
        unique case (s.st)
            PT_RELEASED: begin
                if (connect_request) begin
                    // Every new connection opens in clear
                    next_s.st       = PT_CLEAR;
                    next_s.resume   = 1'b0;
                    next_s.tx_enc   = 1'b0;
                    next_s.rx_dec   = 1'b0;
                    next_s.rx_disc  = 1'b0;
                    next_s.ks_run   = 1'b0;
                    next_s.mode_enc = 1'b0;
                end
            end
            PT_CLEAR: begin
                if (duplex_ok && (cipher_switch_request
                        || (handover_done && s.resume))) begin
                    // This end alone opens a switch
                    next_s.st     = PT_START_REQ;
                    next_s.tries  = 3'h0;
                    next_s.resume = 1'b0;
                end
            end
            PT_START_REQ: begin
                if (rx_ok && link.ft_tail_cmd == CMD_CIPHER_START_CONFIRM) begin
                    // Confirm frame itself is decrypted
                    next_s.st      = PT_START_GRANT;
                    next_s.cfm     = 1'b1;
                    next_s.rx_dec  = 1'b1;
                    next_s.rx_disc = 1'b0;
                end else if (send_slot) begin
                    if (s.tries == REQ_TRIES) begin
                        next_s.st       = PT_RELEASED;
                        next_s.disc     = 1'b1;
                        next_s.tx_enc   = 1'b0;
                        next_s.rx_dec   = 1'b0;
                        next_s.rx_disc  = 1'b0;
                        next_s.ks_run   = 1'b0;
                        next_s.mode_enc = 1'b0;
                    end else begin
                        // Tail leaves outside the key stream
                        next_s.tx_valid = 1'b1;
                        next_s.tx_cmd   = CMD_START_REQUEST;
                        next_s.tries    = s.tries + 3'h1;
                        next_s.rx_disc  = 1'b1;
                        next_s.ks_run   = 1'b1;
                    end
                end
            end
            PT_START_GRANT: begin
                if (grant_frame) begin
                    next_s.tx_enc = 1'b1;
                end
                if (send_slot) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_cmd   = CMD_START_GRANT;
                    next_s.tx_enc   = 1'b1;
                    next_s.mode_enc = 1'b1;
                    next_s.st       = PT_ENCRYPTED;
                end
            end
            PT_ENCRYPTED: begin
                if (duplex_ok && cipher_switch_request) begin
                    next_s.st    = PT_STOP_REQ;
                    next_s.tries = 3'h0;
                end
            end
            PT_STOP_REQ: begin
                if (rx_ok && link.ft_tail_cmd == CMD_CIPHER_STOP_CONFIRM) begin
                    // Confirm frame itself is taken as clear
                    next_s.st      = PT_STOP_GRANT;
                    next_s.cfm     = 1'b1;
                    next_s.rx_dec  = 1'b0;
                    next_s.rx_disc = 1'b0;
                    next_s.ks_run  = 1'b0;
                end else if (send_slot) begin
                    if (s.tries == REQ_TRIES) begin
                        next_s.st       = PT_RELEASED;
                        next_s.disc     = 1'b1;
                        next_s.tx_enc   = 1'b0;
                        next_s.rx_dec   = 1'b0;
                        next_s.rx_disc  = 1'b0;
                        next_s.ks_run   = 1'b0;
                        next_s.mode_enc = 1'b0;
                    end else begin
                        next_s.tx_valid = 1'b1;
                        next_s.tx_cmd   = CMD_STOP_REQUEST;
                        next_s.tries    = s.tries + 3'h1;
                        next_s.rx_disc  = 1'b1;
                    end
                end
            end
            PT_STOP_GRANT: begin
                if (grant_frame) begin
                    next_s.tx_enc = 1'b0;
                end
                if (send_slot) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_cmd   = CMD_STOP_GRANT;
                    next_s.tx_enc   = 1'b0;
                    next_s.mode_enc = 1'b0;
                    // Remember to re-encrypt after handover
                    next_s.resume   = 1'b1;
                    next_s.st       = PT_CLEAR;
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '{st: PT_CLEAR, tx_cmd: CMD_NONE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign link.pt_tail_valid         = s.tx_valid;
    assign link.pt_tail_cmd           = s.tx_cmd;
    assign cipher_switch_confirmation = s.cfm;
    assign disconnect_indication      = s.disc;
    assign tx_encrypt                 = s.tx_enc;
    assign rx_decrypt                 = s.rx_dec;
    assign rx_discard                 = s.rx_disc;
    assign rx_keystream_run           = s.ks_run;
    // One mode flag steers every bearer
    assign bearer_mode_encrypted      = s.mode_enc;
    assign connected                  = (s.st != PT_RELEASED);

endmodule
`default_nettype wire

// ==== rtl/ccs_regs.svh ====
// Purpose: Timing counts and limits for the cipher mode switch handshake
// Assumes: One 50 MHz system clock shared by both ends
// Notes:   Function
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CCS_CLK_MHZ        50
`define CCS_FRAME_TIME_US  10000
`define CCS_FRAME_CYCLES   (`CCS_FRAME_TIME_US * `CCS_CLK_MHZ)
`define CCS_CNT_W          19

// ---------------------------------------------------------------
// Limits
// ---------------------------------------------------------------
`define CCS_FNUM_W         4
`define CCS_REQ_TRIES      3'h5
`define CCS_CONFIRM_SENDS  3'h6

`endif

// ==== rtl/ccs_pkg.sv ====
// Purpose: Types shared by both ends of the handshake
// Assumes: Nothing
// Notes:   Tail command codes carried on the link
package ccs_pkg;

    // ---------------------------------------------------------------
    // Tail commands
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_START_REQUEST,
        CMD_CIPHER_START_CONFIRM,
        CMD_START_GRANT,
        CMD_STOP_REQUEST,
        CMD_CIPHER_STOP_CONFIRM,
        CMD_STOP_GRANT
    } ccs_cmd_e;

    typedef enum logic [2:0] {
        PT_CLEAR, PT_START_REQ, PT_START_GRANT,
        PT_ENCRYPTED, PT_STOP_REQ, PT_STOP_GRANT, PT_RELEASED
    } ccs_pt_state_e;

    typedef enum logic [2:0] {
        FT_CLEAR, FT_START_CONFIRM, FT_ENCRYPTED,
        FT_STOP_CONFIRM, FT_RELEASED
    } ccs_ft_state_e;

    function automatic logic ccs_is_even(input logic [3:0] fnum);
        return ~fnum[0];
    endfunction

endpackage

// ==== rtl/ccs_link_if.sv ====
// Purpose: Link between portable and fixed ends
// Assumes: Both ends on clk_sys
// Notes:   Fixed end owns frame timing
`timescale 1ns/1ps
`default_nettype none
interface ccs_link_if;
    import ccs_pkg::*;

    logic       frame_tick;     // Frame start pulse
    logic       half_tick;      // Mid frame pulse
    logic [3:0] frame_num;      // Current frame number
    logic       ft_tail_valid;  // Fixed tail message pulse
    ccs_cmd_e   ft_tail_cmd;    // Fixed tail command
    logic       pt_tail_valid;  // Portable tail message pulse
    ccs_cmd_e   pt_tail_cmd;    // Portable tail command

    modport fixed_side (
        output frame_tick, half_tick, frame_num, ft_tail_valid, ft_tail_cmd,
        input  pt_tail_valid, pt_tail_cmd
    );

    modport portable_side (
        input  frame_tick, half_tick, frame_num, ft_tail_valid, ft_tail_cmd,
        output pt_tail_valid, pt_tail_cmd
    );
endinterface
`default_nettype wire

// ==== rtl/ccs_fixed_end.sv ====
// Purpose: Fixed end of the cipher mode switch handshake
// Assumes: This end owns frame timing for the link
// Notes:   Key stream and payload path live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_fixed_end
    import ccs_pkg::*;
#(
    parameter int FRAME_CYCLES = `CCS_FRAME_CYCLES
)(
    input  wire logic      clk_sys,                  // System clock
    input  wire logic      rst,                      // Async reset
    ccs_link_if.fixed_side link,                     // Link to portable end
    input  wire logic      duplex_ok,                // Duplex bearer up
    input  wire logic      connect_request,          // Reopen pulse
    output logic           cipher_switch_indication, // Grant seen pulse
    output logic           disconnect_indication,    // Release pulse
    output logic           tx_encrypt,               // Encrypt sent data
    output logic           rx_decrypt,               // Decrypt received
    output logic           rx_discard,               // Ignore received
    output logic           bearer_mode_encrypted,    // Mode for bearers
    output logic           connected                 // Connection live
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        ccs_ft_state_e          st;
        logic [`CCS_CNT_W-1:0]  cyc;
        logic [3:0]             fnum;
        logic                   ftick;
        logic                   htick;
        logic [2:0]             sends;
        logic                   tx_valid;
        ccs_cmd_e               tx_cmd;
        logic                   tx_enc;
        logic                   rx_dec;
        logic                   rx_disc;
        logic                   mode_enc;
        logic                   ind;
        logic                   disc;
    } ccs_ft_s;

    localparam logic [`CCS_CNT_W-1:0] LAST_CYC = `CCS_CNT_W'(FRAME_CYCLES - 1);
    localparam logic [`CCS_CNT_W-1:0] HALF_CYC = `CCS_CNT_W'(FRAME_CYCLES / 2 - 1);
    localparam logic [2:0]            SENDS    = `CCS_CONFIRM_SENDS;

    ccs_ft_s    s;
    ccs_ft_s    next_s;
    logic       rx_ok;
    logic       wrap;
    logic [3:0] nf;

    assign rx_ok = link.pt_tail_valid & duplex_ok;
    assign wrap  = (s.cyc == LAST_CYC);
    assign nf    = s.fnum + 4'h1;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s          = s;
        next_s.ftick    = wrap;
        next_s.htick    = (s.cyc == HALF_CYC);
        next_s.tx_valid = 1'b0;
        next_s.tx_cmd   = CMD_NONE;
        next_s.ind      = 1'b0;
        next_s.disc     = 1'b0;
        next_s.cyc      = wrap ? '0 : s.cyc + `CCS_CNT_W'(1);
        if (wrap) begin
            next_s.fnum = nf;
        end
        unique case (s.st)
            FT_RELEASED: begin
                if (connect_request) begin
                    next_s.st      = FT_CLEAR;
                    next_s.rx_dec  = 1'b0;
                    next_s.rx_disc = 1'b0;
                end
            end
            FT_CLEAR, FT_ENCRYPTED: begin
                // Requests only ever come from the portable end
                if (rx_ok && s.st == FT_CLEAR && link.pt_tail_cmd == CMD_START_REQUEST) begin
                    next_s.st       = FT_START_CONFIRM;
                    next_s.tx_enc   = 1'b1;
                    next_s.mode_enc = 1'b1;
                    next_s.sends    = 3'h0;
                end
                if (rx_ok && s.st == FT_ENCRYPTED && link.pt_tail_cmd == CMD_STOP_REQUEST) begin
                    next_s.st       = FT_STOP_CONFIRM;
                    next_s.tx_enc   = 1'b0;
                    next_s.mode_enc = 1'b0;
                    next_s.sends    = 3'h0;
                end
            end
            FT_START_CONFIRM, FT_STOP_CONFIRM: begin
                if (rx_ok && ((s.st == FT_START_CONFIRM && link.pt_tail_cmd == CMD_START_GRANT)
                        || (s.st == FT_STOP_CONFIRM && link.pt_tail_cmd == CMD_STOP_GRANT))) begin
                    // Grant frame decoded in the new mode
                    next_s.rx_dec  = (s.st == FT_START_CONFIRM);
                    next_s.rx_disc = 1'b0;
                    next_s.ind     = 1'b1;
                    next_s.st      = (s.st == FT_START_CONFIRM) ? FT_ENCRYPTED : FT_CLEAR;
                end else if (wrap && !ccs_is_even(nf)) begin
                    // Odd frame start is this end's send slot
                    if (s.sends == SENDS) begin
                        next_s.st       = FT_RELEASED;
                        next_s.disc     = 1'b1;
                        next_s.tx_enc   = 1'b0;
                        next_s.rx_dec   = 1'b0;
                        next_s.rx_disc  = 1'b0;
                        next_s.mode_enc = 1'b0;
                    end else begin
                        next_s.tx_valid = 1'b1;
                        next_s.tx_cmd   = (s.st == FT_START_CONFIRM) ?
                                          CMD_CIPHER_START_CONFIRM :
                                          CMD_CIPHER_STOP_CONFIRM;
                        next_s.sends    = s.sends + 3'h1;
                    end
                end else if (wrap && s.sends != 3'h0) begin
                    // Frame 2S+1 was taken in the old mode
                    next_s.rx_disc = 1'b1;
                end
            end
            default: begin
                next_s.st = FT_RELEASED;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '{st: FT_CLEAR, tx_cmd: CMD_NONE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign link.frame_tick        = s.ftick;
    assign link.half_tick         = s.htick;
    assign link.frame_num         = s.fnum;
    assign link.ft_tail_valid     = s.tx_valid;
    assign link.ft_tail_cmd       = s.tx_cmd;
    assign cipher_switch_indication = s.ind;
    assign disconnect_indication  = s.disc;
    assign tx_encrypt             = s.tx_enc;
    assign rx_decrypt             = s.rx_dec;
    assign rx_discard             = s.rx_disc;
    assign bearer_mode_encrypted  = s.mode_enc;
    assign connected              = (s.st != FT_RELEASED);

endmodule
`default_nettype wire

// ==== test/ccs_link_asserts.sv ====
// Purpose: Link checks for the cipher mode switch handshake
// Assumes: Both ends on clk_sys
// Notes:   Watches the shared interface only
`timescale 1ns/1ps
`default_nettype none
module ccs_link_asserts
    import ccs_pkg::*;
#(parameter int FRAME_CYCLES = 40)(
    input wire logic       clk_sys,       // Clock
    input wire logic       rst,           // Reset
    input wire logic       frame_tick,    // Frame start
    input wire logic       half_tick,     // Mid frame
    input wire logic [3:0] frame_num,     // Frame number
    input wire logic       ft_tail_valid, // Fixed tail
    input wire ccs_cmd_e   ft_tail_cmd,   // Fixed command
    input wire logic       pt_tail_valid, // Portable tail
    input wire ccs_cmd_e   pt_tail_cmd    // Portable command
);
    localparam int HALF = FRAME_CYCLES / 2;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_grant(ccs_cmd_e c); pt_tail_valid && pt_tail_cmd == c; endsequence
    a_pt_slot: assert property (pt_tail_valid |-> !frame_num[0] && $past(half_tick))
        else $error("portable tail off slot");
    a_ft_slot: assert property (ft_tail_valid |-> frame_tick && frame_num[0])
        else $error("fixed tail off slot");
    a_num_step: assert property (frame_tick |-> frame_num == $past(frame_num) + 4'h1)
        else $error("frame number did not step");
    a_half_mid: assert property (frame_tick |-> ##HALF half_tick)
        else $error("half tick misplaced");
    a_tick_gap: assert property (frame_tick |=> !frame_tick [*8])
        else $error("frame ticks too close");
    a_ft_cmds: assert property (ft_tail_valid |-> ft_tail_cmd inside
        {CMD_CIPHER_START_CONFIRM, CMD_CIPHER_STOP_CONFIRM}) else $error("fixed sent non confirm");
    a_start_end: assert property (s_grant(CMD_START_GRANT) |->
        ##[1:FRAME_CYCLES] frame_tick && !ft_tail_valid) else $error("confirm after grant");
    a_stop_end: assert property (s_grant(CMD_STOP_GRANT) |->
        ##[1:FRAME_CYCLES] frame_tick && !ft_tail_valid) else $error("stop confirm after grant");
endmodule
`default_nettype wire

// ==== test/cipher_mode_switch_handshake_tb.sv ====
// Purpose: Bench for both ends of the cipher mode switch handshake
// Assumes: Frames shortened to 40 cycles
// Notes:   Timeouts forced by dropping duplex_ok on one end
`timescale 1ns/1ps
`default_nettype none
module cipher_mode_switch_handshake_tb;
    import ccs_pkg::*;
    localparam int FC = 40;
    logic clk_sys = 1'b0, rst = 1'b1, p_dup = 1'b1, f_dup = 1'b1, req = 1'b0, hod = 1'b0;
    logic cr = 1'b0, p_cfm, p_dis, p_txe, p_rxd, p_rxx, p_bme, p_con, p_ks;
    logic f_ind, f_dis, f_txe, f_rxd, f_rxx, f_bme, f_con;
    int n_fail = 0, check_count = 0, n_req = 0, n_conf = 0, i, k, j;
    always #10 clk_sys = ~clk_sys;
    ccs_link_if link ();
    ccs_portable_end ccs_portable_end_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
        .duplex_ok(p_dup), .cipher_switch_request(req), .handover_done(hod),
        .connect_request(cr), .cipher_switch_confirmation(p_cfm), .disconnect_indication(p_dis),
        .tx_encrypt(p_txe), .rx_decrypt(p_rxd), .rx_discard(p_rxx), .rx_keystream_run(p_ks),
        .bearer_mode_encrypted(p_bme), .connected(p_con));
    ccs_fixed_end #(.FRAME_CYCLES(FC)) ccs_fixed_end_inst (.clk_sys(clk_sys), .rst(rst),
        .link(link), .duplex_ok(f_dup), .connect_request(cr), .cipher_switch_indication(f_ind),
        .disconnect_indication(f_dis), .tx_encrypt(f_txe), .rx_decrypt(f_rxd),
        .rx_discard(f_rxx), .bearer_mode_encrypted(f_bme), .connected(f_con));
    ccs_link_asserts #(.FRAME_CYCLES(FC)) ccs_link_asserts_inst (.clk_sys(clk_sys), .rst(rst),
        .frame_tick(link.frame_tick), .half_tick(link.half_tick), .frame_num(link.frame_num),
        .ft_tail_valid(link.ft_tail_valid), .ft_tail_cmd(link.ft_tail_cmd),
        .pt_tail_valid(link.pt_tail_valid), .pt_tail_cmd(link.pt_tail_cmd));
    always @(negedge clk_sys) begin
        if (link.pt_tail_valid === 1'b1 && link.pt_tail_cmd inside {CMD_START_REQUEST, CMD_STOP_REQUEST})
            n_req++;
        if (link.ft_tail_valid === 1'b1)
            n_conf++;
    end
    task automatic chk(string nm, logic e, logic g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_n(string nm, int e, int g);
        check_count++;
        if (g != e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wait_hi(string nm, ref logic s);
        for (i = 0; i < 600 && s !== 1'b1; i++) @(negedge clk_sys);
        chk(nm, 1'b1, s);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    // One full start or stop on a good link
    task automatic t_switch(logic on);
        k = n_req;
        pulse(req);
        wait_hi("pt_confirmation", p_cfm);
        chk("pt_rx_decrypt", on, p_rxd);
        chk("pt_rx_discard", 1'b0, p_rxx);
        chk("pt_keystream", on, p_ks);
        chk("ft_tx_encrypt", on, f_txe);
        chk("ft_rx_decrypt", !on, f_rxd);
        chk("pt_tx_encrypt", !on, p_txe);
        wait_hi("ft_indication", f_ind);
        chk("ft_rx_decrypt", on, f_rxd);
        chk("ft_rx_discard", 1'b0, f_rxx);
        chk("pt_tx_encrypt", on, p_txe);
        chk("pt_bearer_mode", on, p_bme);
        chk("ft_bearer_mode", on, f_bme);
        chk_n("requests_sent", 1, n_req - k);
    endtask
    task automatic t_ft_timeout();
        k = n_conf;
        j = n_req;
        pulse(req);
        for (i = 0; i < 100 && n_req == j; i++) @(negedge clk_sys);
        p_dup = 1'b0;
        wait_hi("pt_disconnect", p_dis);
        wait_hi("ft_disconnect", f_dis);
        chk_n("confirms_sent", 6, n_conf - k);
        chk("ft_connected", 1'b0, f_con);
        pulse(cr);
        p_dup = 1'b1;
        chk("reconnected", 1'b1, p_con & f_con);
    endtask
    task automatic t_pt_timeout();
        k = n_req;
        f_dup = 1'b0;
        pulse(req);
        wait_hi("pt_disconnect", p_dis);
        chk_n("requests_sent", 5, n_req - k);
        chk("pt_connected", 1'b0, p_con);
        chk("ft_still_up", 1'b1, f_con);
        chk("ft_tx_encrypt", 1'b0, f_txe);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk("connected", 1'b1, p_con & f_con);
        chk("clear_at_reset", 1'b0, p_txe | f_txe | p_bme | f_bme);
        t_switch(1'b1);
        t_switch(1'b0);
        pulse(hod);
        wait_hi("ft_indication", f_ind);
        chk("resumed_mode", 1'b1, p_bme & f_bme);
        t_ft_timeout();
        t_pt_timeout();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
